// ---- verilog/page_stack_pkg.sv ----
// package: register map, field layout and bus carrier of the page stack
`default_nettype none
package page_stack_pkg;
   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int PAGE_W = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_ACTIVE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_SECOND = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_BOTTOM = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h00C;

   // ****************************************************************
   // fields and reset values
   // ****************************************************************
   localparam int                AUTO_EN_BIT  = 0;
   localparam logic              AUTO_EN_RST  = 1'b1;
   localparam logic [PAGE_W-1:0] PAGE_RST     = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RST    = 32'h0000_0000;

   // ****************************************************************
   // bus carriers
   // ****************************************************************
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } apb_rsp_t;

   // register selector decoded from the address
   typedef enum logic [2:0] {
      SEL_ACTIVE = 3'h0,
      SEL_SECOND = 3'h1,
      SEL_BOTTOM = 3'h2,
      SEL_CTRL   = 3'h3,
      SEL_NONE   = 3'h4
   } reg_sel_t;
endpackage
`default_nettype wire

// ---- verilog/page_stack.sv ----
// top: three-level register-page context stack with an APB slave
//
// Function
// - return loads active page from second level
// - return copies bottom level into second level
// - three stack levels readable and writable separately
// - handler writes change what return restores
// - push only on interrupt service
// - pop only on interrupt return instruction
// - auto enable cleared stops push and pop
//
// The register addresses and the APB register port are this design's own decisions.
`default_nettype none
module page_stack
(
   input  wire logic                             I_CORE_CLK,
   input  wire logic                             I_NRST,
   input  wire page_stack_pkg::apb_req_t         I_APB_REQ,
   output page_stack_pkg::apb_rsp_t              O_APB_RSP,
   input  wire logic                             I_IRQ_ENTRY,
   input  wire logic [page_stack_pkg::PAGE_W-1:0] I_IRQ_PAGE,
   input  wire logic                             I_IRQ_RETURN,
   output logic [page_stack_pkg::PAGE_W-1:0]     O_ACTIVE_PAGE,
   output logic [page_stack_pkg::PAGE_W-1:0]     O_SECOND_LEVEL,
   output logic [page_stack_pkg::PAGE_W-1:0]     O_BOTTOM_LEVEL,
   output logic                                  O_AUTO_PAGE_ENABLE
);
   import page_stack_pkg::*;

   // ****************************************************************
   // address decode
   // ****************************************************************

   // shared by the write path and the read path
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      reg_sel_t sel;
      case (addr)
         OFS_ACTIVE : sel = SEL_ACTIVE;
         OFS_SECOND : sel = SEL_SECOND;
         OFS_BOTTOM : sel = SEL_BOTTOM;
         OFS_CTRL   : sel = SEL_CTRL;
         default    : sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   reg_sel_t          sel;
   logic              access;
   logic              setup;
   logic              wr;
   logic [PAGE_W-1:0] wpage;

   // a write lands on the access-phase edge only
   always_comb
   begin
      sel    = decode(I_APB_REQ.paddr);
      setup  = I_APB_REQ.psel && !I_APB_REQ.penable;
      access = I_APB_REQ.psel && I_APB_REQ.penable;
      wr     = access && I_APB_REQ.pwrite;
      wpage  = I_APB_REQ.pwdata[PAGE_W-1:0];
   end

   // ****************************************************************
   // stack state
   // ****************************************************************
   logic [PAGE_W-1:0] active_page_select_q;
   logic [PAGE_W-1:0] second_stack_level_q;
   logic [PAGE_W-1:0] bottom_stack_level_q;
   logic              auto_page_enable_q;
   logic              push;
   logic              pop;

   // only the sequencer's entry and return strobes move the stack;
   // entry wins if both come together, the return is then dropped
   always_comb
   begin
      push = I_IRQ_ENTRY && auto_page_enable_q;
      pop  = I_IRQ_RETURN && !I_IRQ_ENTRY && auto_page_enable_q;
   end

   // active level: a software write in the same cycle overrides
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_NRST)
         active_page_select_q <= PAGE_RST;
      else if (wr && sel == SEL_ACTIVE)
         active_page_select_q <= wpage;
      else if (push)
         active_page_select_q <= I_IRQ_PAGE;
      else if (pop)
         active_page_select_q <= second_stack_level_q;
   end

   // second level
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_NRST)
         second_stack_level_q <= PAGE_RST;
      else if (wr && sel == SEL_SECOND)
         second_stack_level_q <= wpage;
      else if (push)
         second_stack_level_q <= active_page_select_q;
      else if (pop)
         second_stack_level_q <= bottom_stack_level_q;
   end

   // bottom level keeps its value on a pop; nothing sits below it
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_NRST)
         bottom_stack_level_q <= PAGE_RST;
      else if (wr && sel == SEL_BOTTOM)
         bottom_stack_level_q <= wpage;
      else if (push)
         bottom_stack_level_q <= second_stack_level_q;
   end

   // page control register
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_NRST)
         auto_page_enable_q <= AUTO_EN_RST;
      else if (wr && sel == SEL_CTRL)
         auto_page_enable_q <= I_APB_REQ.pwdata[AUTO_EN_BIT];
   end

   // ****************************************************************
   // read path and response
   // ****************************************************************
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] rd_d;

   // zero-extended level or control word; unmapped reads as zero
   always_comb
   begin
      rd_d = RDATA_RST;
      case (sel)
         SEL_ACTIVE : rd_d[PAGE_W-1:0]  = active_page_select_q;
         SEL_SECOND : rd_d[PAGE_W-1:0]  = second_stack_level_q;
         SEL_BOTTOM : rd_d[PAGE_W-1:0]  = bottom_stack_level_q;
         SEL_CTRL   : rd_d[AUTO_EN_BIT] = auto_page_enable_q;
         default    : rd_d = RDATA_RST;
      endcase
   end

   // captured in the setup phase so the data leaves a flip-flop;
   // the cost is that a stack move on the setup-phase edge, where the data is captured, is not seen
   always_ff @(posedge I_CORE_CLK)
   begin
      if (!I_NRST)
         prdata_q <= RDATA_RST;
      else if (setup && !I_APB_REQ.pwrite)
         prdata_q <= rd_d;
   end

   // zero-wait slave; unmapped addresses answer with an error
   always_comb
   begin
      O_APB_RSP.pready  = 1'b1;
      O_APB_RSP.pslverr = access && (sel == SEL_NONE);
      O_APB_RSP.prdata  = prdata_q;
   end

   // state outputs straight from the registers
   always_comb
   begin
      O_ACTIVE_PAGE      = active_page_select_q;
      O_SECOND_LEVEL     = second_stack_level_q;
      O_BOTTOM_LEVEL     = bottom_stack_level_q;
      O_AUTO_PAGE_ENABLE = auto_page_enable_q;
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   logic wr_act;
   logic wr_sec;
   logic wr_bot;
   logic wr_lvl;

   // helper terms for the checks below
   always_comb
   begin
      wr_act = wr && sel == SEL_ACTIVE;
      wr_sec = wr && sel == SEL_SECOND;
      wr_bot = wr && sel == SEL_BOTTOM;
      wr_lvl = wr_act || wr_sec || wr_bot;
   end

   sequence s_pop;
      I_IRQ_RETURN && !I_IRQ_ENTRY && auto_page_enable_q && !wr_lvl;
   endsequence

   sequence s_push;
      I_IRQ_ENTRY && auto_page_enable_q && !wr_lvl;
   endsequence

   sequence s_quiet;
      !I_IRQ_ENTRY && !I_IRQ_RETURN && !wr_lvl;
   endsequence

   property p_pop_active;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      s_pop |=> active_page_select_q == $past(second_stack_level_q);
   endproperty
   a_pop_active : assert property (p_pop_active)
      else $error("return did not load active page from second level");

   property p_pop_second;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      s_pop |=> second_stack_level_q == $past(bottom_stack_level_q)
                && bottom_stack_level_q == $past(bottom_stack_level_q);
   endproperty
   a_pop_second : assert property (p_pop_second)
      else $error("return did not move bottom level into second level");

   property p_sw_write;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      wr_bot |=> bottom_stack_level_q == $past(wpage);
   endproperty
   a_sw_write : assert property (p_sw_write)
      else $error("write to bottom level not stored");

   property p_write_active;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      wr_act |=> active_page_select_q == $past(wpage);
   endproperty
   a_write_active : assert property (p_write_active)
      else $error("write to active page not stored");

   property p_write_second;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      wr_sec |=> second_stack_level_q == $past(wpage);
   endproperty
   a_write_second : assert property (p_write_second)
      else $error("write to second level not stored");

   // the control bit decides whether entry and return move the stack at all
   property p_write_ctrl;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (wr && sel == SEL_CTRL)
         |=> auto_page_enable_q == $past(I_APB_REQ.pwdata[AUTO_EN_BIT]);
   endproperty
   a_write_ctrl : assert property (p_write_ctrl)
      else $error("write to page control not stored");

   property p_write_then_return;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (wr_sec && auto_page_enable_q ##1 s_pop)
         |=> active_page_select_q == $past(wpage, 2);
   endproperty
   a_write_then_return : assert property (p_write_then_return)
      else $error("return did not restore the page written by software");

   property p_no_move;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      s_quiet |=> $stable(active_page_select_q) && $stable(second_stack_level_q)
                  && $stable(bottom_stack_level_q);
   endproperty
   a_no_move : assert property (p_no_move)
      else $error("stack moved without entry, return or write");

   property p_entry_beats_return;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (I_IRQ_ENTRY && I_IRQ_RETURN && auto_page_enable_q && !wr_lvl)
         |=> active_page_select_q == $past(I_IRQ_PAGE);
   endproperty
   a_entry_beats_return : assert property (p_entry_beats_return)
      else $error("return acted while an entry was taken");

   property p_disabled;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (!auto_page_enable_q && !wr_lvl) |=> $stable(active_page_select_q)
         && $stable(second_stack_level_q) && $stable(bottom_stack_level_q);
   endproperty
   a_disabled : assert property (p_disabled)
      else $error("stack moved while auto paging disabled");

   property p_push;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      s_push |=> active_page_select_q == $past(I_IRQ_PAGE)
                 && second_stack_level_q == $past(active_page_select_q)
                 && bottom_stack_level_q == $past(second_stack_level_q);
   endproperty
   a_push : assert property (p_push)
      else $error("entry did not shift the stack and load the source page");

   property p_push_pop_round;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (s_push ##1 s_pop) |=> active_page_select_q == $past(active_page_select_q, 2);
   endproperty
   a_push_pop_round : assert property (p_push_pop_round)
      else $error("entry then return did not restore the page");

   property p_unmapped;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      access |-> O_APB_RSP.pslverr == (sel == SEL_NONE) && O_APB_RSP.pready;
   endproperty
   a_unmapped : assert property (p_unmapped)
      else $error("error response wrong for access");

   property p_read_active;
      @(posedge I_CORE_CLK) disable iff (!I_NRST)
      (setup && !I_APB_REQ.pwrite && sel == SEL_ACTIVE)
         |=> O_APB_RSP.prdata == {24'h000000, $past(active_page_select_q)};
   endproperty
   a_read_active : assert property (p_read_active)
      else $error("read of active page returned wrong data");
endmodule
`default_nettype wire

// ---- sim/irq_seq_model.sv ----
// model of the core's interrupt sequencer: entry and return pulses
`default_nettype none
module irq_seq_model
(
   input  wire logic                              i_clk,
   output logic                                   o_entry,
   output logic [page_stack_pkg::PAGE_W-1:0]      o_page,
   output logic                                   o_return
);
   timeunit 1ns;
   timeprecision 1ps;
   import page_stack_pkg::*;

   // idle at time zero, no event pending
   initial
   begin
      o_entry  = 1'b0;
      o_return = 1'b0;
      o_page   = '0;
   end

   // one-cycle service pulse; page is only valid with it, so it flips afterwards
   task automatic enter(input logic [PAGE_W-1:0] p);
      @(posedge i_clk);
      o_entry <= 1'b1;
      o_page  <= p;
      @(posedge i_clk);
      o_entry <= 1'b0;
      o_page  <= ~p;
   endtask

   // one-cycle return-from-interrupt pulse
   task automatic leave();
      @(posedge i_clk);
      o_return <= 1'b1;
      @(posedge i_clk);
      o_return <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- sim/page_stack_tb.sv ----
// testbench of the page context stack: apb access and interrupt traffic
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module page_stack_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import page_stack_pkg::*;

   logic              clk;
   logic              nrst;
   apb_req_t          req;
   apb_rsp_t          rsp;
   logic              entry;
   logic [PAGE_W-1:0] page;
   logic              ret;
   logic [PAGE_W-1:0] act;
   logic [PAGE_W-1:0] sec;
   logic [PAGE_W-1:0] bot;
   logic              en;
   int                n_fail;
   int                n_compared;

   page_stack i_page_stack (.I_CORE_CLK(clk), .I_NRST(nrst), .I_APB_REQ(req),
      .O_APB_RSP(rsp), .I_IRQ_ENTRY(entry), .I_IRQ_PAGE(page), .I_IRQ_RETURN(ret),
      .O_ACTIVE_PAGE(act), .O_SECOND_LEVEL(sec), .O_BOTTOM_LEVEL(bot),
      .O_AUTO_PAGE_ENABLE(en));
   irq_seq_model i_irq_seq_model (.i_clk(clk), .o_entry(entry), .o_page(page),
      .o_return(ret));

   // ****************************************************************
   // clock, verdict and bus tasks
   // ****************************************************************
   // 250 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic results();
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one apb transfer; a stuck slave is caught by the watchdog, not here
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                       output logic err);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] rd;
      logic              err;
      xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                       input logic ee);
      logic [DATA_W-1:0] rd;
      logic              err;
      xfer(1'b0, a, '0, rd, err);
      `CHK("prdata", e, rd)
      `CHK("pslverr", ee, err)
   endtask

   // stack outputs, looked at once the event edge has landed
   task automatic stk(input logic [PAGE_W-1:0] a, input logic [PAGE_W-1:0] s,
                      input logic [PAGE_W-1:0] b);
      #1;
      `CHK("active", a, act)
      `CHK("second", s, sec)
      `CHK("bottom", b, bot)
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   // a hang counts as a mismatch and ends the run the same way
   initial
   begin
      repeat (2000) @(posedge clk);
      n_fail++;
      results();
   end

   // reset, then register, push, pop and disable scenarios
   initial
   begin
      n_fail = 0;
      n_compared = 0;
      nrst = 1'b0;
      req  = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rchk(OFS_ACTIVE, 32'(PAGE_RST), 1'b0);
      rchk(OFS_SECOND, 32'(PAGE_RST), 1'b0);
      rchk(OFS_BOTTOM, 32'(PAGE_RST), 1'b0);
      rchk(OFS_CTRL, 32'(AUTO_EN_RST), 1'b0);
      rchk(12'h010, 32'h0000_0000, 1'b1);
      wr(OFS_BOTTOM, 32'hFFFF_FF5A);
      wr(OFS_SECOND, 32'h0000_00C3);
      wr(OFS_ACTIVE, 32'h0000_000F);
      rchk(OFS_BOTTOM, 32'h0000_005A, 1'b0);
      rchk(OFS_SECOND, 32'h0000_00C3, 1'b0);
      rchk(OFS_ACTIVE, 32'h0000_000F, 1'b0);
      stk(8'h0F, 8'hC3, 8'h5A);
      i_irq_seq_model.enter(8'h21);
      stk(8'h21, 8'h0F, 8'hC3);
      i_irq_seq_model.enter(8'h00);
      stk(8'h00, 8'h21, 8'h0F);
      i_irq_seq_model.leave();
      stk(8'h21, 8'h0F, 8'h0F);
      i_irq_seq_model.leave();
      stk(8'h0F, 8'h0F, 8'h0F);
      // a handler rewrites the saved page before returning
      i_irq_seq_model.enter(8'h33);
      wr(OFS_SECOND, 32'h0000_0044);
      i_irq_seq_model.leave();
      stk(8'h44, 8'h0F, 8'h0F);
      wr(OFS_CTRL, 32'h0000_0000);
      rchk(OFS_CTRL, 32'h0000_0000, 1'b0);
      #1;
      `CHK("auto_en", 1'b0, en)
      i_irq_seq_model.enter(8'h55);
      stk(8'h44, 8'h0F, 8'h0F);
      i_irq_seq_model.leave();
      stk(8'h44, 8'h0F, 8'h0F);
      wr(OFS_CTRL, 32'h0000_0001);
      i_irq_seq_model.enter(8'h66);
      stk(8'h66, 8'h44, 8'h0F);
      // entry and return on one edge: the entry is taken, the return dropped
      fork
         i_irq_seq_model.enter(8'h77);
         i_irq_seq_model.leave();
      join
      stk(8'h77, 8'h66, 8'h44);
      // return in the very cycle after the entry
      fork
         i_irq_seq_model.enter(8'h88);
         begin
            @(posedge clk);
            i_irq_seq_model.leave();
         end
      join
      stk(8'h77, 8'h66, 8'h66);
      // return strobe right after the write's access edge
      fork
         wr(OFS_SECOND, 32'h0000_0099);
         begin
            repeat (2) @(posedge clk);
            i_irq_seq_model.leave();
         end
      join
      stk(8'h99, 8'h66, 8'h66);
      results();
   end
endmodule
`undef CHK
`default_nettype wire
